// File: hdl/lgst_defs.svh
`ifndef LGST_DEFS_SVH
`define LGST_DEFS_SVH
`define LGST_OFS_PIN9 8'h1A
`define LGST_OFS_LINK0 8'h1D
`define LGST_OFS_LINK12 8'h1E
`define LGST_OFS_LINK3 8'h1F
`define LGST_OFS_REG56 8'h20
`define LGST_OFS_REG78 8'h21
`define LGST_OFS_BCCTL 8'h23
`define LGST_OFS_PSEL 8'h34
`define LGST_OFS_CCMODE 8'h43
`define LGST_OFS_LVL_LO 8'h6E
`define LGST_OFS_LVL_HI 8'h6F
`define LGST_CODE_FWD 4'h5
`define LGST_CODE_IN 4'h3
`define LGST_CODE_LOW 4'h1
`define LGST_CODE_HIGH 4'h9
`define LGST_BIT_DIVSEL 6
`define LGST_BIT_FASTBC 4
`define LGST_RST_CFG 8'h00
`define LGST_RST_PSEL 8'h01
`define LGST_DIV_SLOW 2'h3
`define LGST_DIV_MID 2'h1
`define LGST_DIV_FAST 2'h0
`define LGST_SMP_NORMAL 4'h1
`define LGST_SMP_FAST4 4'h6
`define LGST_SMP_FAST2 4'hA
`define LGST_SMP_FAST1 4'hF
`endif

// File: hdl/lgst_pkg.sv
package lgst_pkg;
	typedef enum logic [2:0] {
		LGST_CC_NORMAL = 3'b000,
		LGST_CC_FAST1 = 3'b001,
		LGST_CC_FAST2 = 3'b010,
		LGST_CC_FAST4 = 3'b011,
		LGST_CC_SPI_FWD = 3'b110,
		LGST_CC_SPI_REV = 3'b111
	} lgst_cc_mode_type;

	typedef struct packed {
		logic [2:0][7:0] std_cfg;
		logic [2:0][7:0] hs_cfg;
		logic [7:0] pin9_cfg;
		logic [7:0] reg56_cfg;
		logic [7:0] reg78_cfg;
		logic [7:0] bc_ctl;
		logic [7:0] port_sel;
		logic [7:0] cc_mode;
		logic strap_done;
		logic [3:0] gpio_o;
		logic [3:0] gpio_oe_n;
		logic [3:0] hs_o;
		logic [3:0] hs_oe_n;
		logic [3:0] loc_o;
		logic [3:0] loc_oe_n;
		logic pin9_o;
		logic pin9_oe_n;
		logic [3:0] aud;
		logic [1:0] div_cnt;
		logic bc_bit;
		logic [3:0] smp_cnt;
		logic hs_valid;
		logic [3:0] hs_data;
		logic [3:0] bc_gpio;
		logic sck_prev;
		logic sck_o;
		logic mosi_o;
		logic ss_n_o;
		logic rsck_prev;
		logic rpend;
		logic rmosi;
		logic spi_valid;
		logic spi_mosi;
		logic spi_ss_n;
		logic [7:0] rdata;
	} lgst_state_type;
endpackage

// File: hdl/lgst_gpio_tunnel.sv
`include "lgst_defs.svh"

module lgst_gpio_tunnel
	import lgst_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	output logic [7:0] reg_rdata,
	// Link status and strap
	input wire logic two_lane,
	input wire logic strap_mode_select,
	// Forward frame fields, one strobe per pixel clock
	input wire logic fwd_strobe,
	input wire logic [3:0] fwd_gpio,
	input wire logic [3:0] fwd_hs_gpio,
	input wire logic fwd_spi_clk,
	input wire logic fwd_spi_mosi,
	input wire logic fwd_spi_ss_n,
	// Back channel timing
	input wire logic osc_tick,
	input wire logic bc_frame_start,
	output logic bc_bit_strobe,
	output logic [3:0] bc_gpio,
	output logic bc_hs_valid,
	output logic [3:0] bc_hs_data,
	output logic bc_spi_valid,
	output logic bc_spi_mosi,
	output logic bc_spi_ss_n,
	// Standard link pins
	input wire logic [3:0] gpio_in,
	output logic [3:0] gpio_out,
	output logic [3:0] gpio_oe_n,
	// High-speed link pins
	input wire logic [3:0] hs_gpio_in,
	output logic [3:0] hs_gpio_out,
	output logic [3:0] hs_gpio_oe_n,
	// Register-only pins 5..8 and pin 9
	input wire logic [3:0] loc_in,
	output logic [3:0] loc_out,
	output logic [3:0] loc_oe_n,
	input wire logic pin9_in,
	output logic pin9_out,
	output logic pin9_oe_n,
	// Shared audio inputs
	input wire logic [3:0] aud_pin_in,
	output logic [3:0] aud_data,
	// Forward SPI outputs
	output logic tunnel_spi_clock,
	output logic spi_mosi,
	output logic spi_ss_n,
	// Reverse SPI master inputs
	input wire logic rev_spi_clk,
	input wire logic rev_spi_mosi,
	input wire logic rev_spi_ss_n
);

	lgst_state_type s_reg;
	lgst_state_type s_next;

	function automatic logic [3:0] link_code(input logic [2:0][7:0] c, input int i);
		case (i)
			0: link_code = c[0][3:0];
			1: link_code = c[1][3:0];
			2: link_code = c[1][7:4];
			default: link_code = c[2][3:0];
		endcase
	endfunction

	function automatic logic is_local(input logic [3:0] c);
		is_local = (c == `LGST_CODE_LOW) || (c == `LGST_CODE_HIGH) || (c == `LGST_CODE_IN);
	endfunction

	logic [2:0] cc;
	logic fast_bc;
	logic [1:0] div_last;
	logic [3:0] carried;
	logic [3:0] smp_lim;
	logic spi_fwd;
	logic spi_rev;
	logic hs_ok;
	logic [3:0] lvl;
	logic rev_edge;
	logic [3:0] c;
	logic [7:0] idx;

	always_comb begin
		s_next = s_reg;
		cc = s_reg.cc_mode[2:0];
		spi_fwd = two_lane && (cc == LGST_CC_SPI_FWD);
		spi_rev = two_lane && (cc == LGST_CC_SPI_REV);
		hs_ok = two_lane && (cc[2:1] != 2'b11);
		case (cc)
			LGST_CC_FAST4: begin
				carried = 4'hF;
				smp_lim = `LGST_SMP_FAST4;
			end
			LGST_CC_FAST2: begin
				carried = 4'h3;
				smp_lim = `LGST_SMP_FAST2;
			end
			LGST_CC_FAST1: begin
				carried = 4'h1;
				smp_lim = `LGST_SMP_FAST1;
			end
			default: begin
				carried = 4'hF;
				smp_lim = `LGST_SMP_NORMAL;
			end
		endcase
		idx = reg_addr - `LGST_OFS_LINK0;
		// Strap loads the fast bit once after reset release
		if (!s_reg.strap_done) begin
			s_next.bc_ctl[`LGST_BIT_FASTBC] = strap_mode_select;
			s_next.strap_done = 1'b1;
		end
		// Register writes; the SPI tunnel has no path here
		if (reg_wr) begin
			case (reg_addr)
				`LGST_OFS_LINK0, `LGST_OFS_LINK12, `LGST_OFS_LINK3: begin
					if (s_reg.port_sel[0]) s_next.std_cfg[idx[1:0]] = reg_wdata;
					if (s_reg.port_sel[1]) s_next.hs_cfg[idx[1:0]] = reg_wdata;
				end
				`LGST_OFS_PIN9: s_next.pin9_cfg = reg_wdata;
				`LGST_OFS_REG56: s_next.reg56_cfg = reg_wdata;
				`LGST_OFS_REG78: s_next.reg78_cfg = reg_wdata;
				`LGST_OFS_BCCTL: s_next.bc_ctl = reg_wdata;
				`LGST_OFS_PSEL: s_next.port_sel = reg_wdata;
				`LGST_OFS_CCMODE: s_next.cc_mode = reg_wdata;
				// No local video-mode setting, it arrives over the link
				default: ;
			endcase
		end
		// Read data, one cycle after the address
		lvl = s_reg.port_sel[1] ? hs_gpio_in : gpio_in;
		case (reg_addr)
			`LGST_OFS_LINK0, `LGST_OFS_LINK12, `LGST_OFS_LINK3:
				s_next.rdata = s_reg.port_sel[1] ? s_reg.hs_cfg[idx[1:0]] :
					s_reg.std_cfg[idx[1:0]];
			`LGST_OFS_PIN9: s_next.rdata = s_reg.pin9_cfg;
			`LGST_OFS_REG56: s_next.rdata = s_reg.reg56_cfg;
			`LGST_OFS_REG78: s_next.rdata = s_reg.reg78_cfg;
			`LGST_OFS_BCCTL: s_next.rdata = s_reg.bc_ctl;
			`LGST_OFS_PSEL: s_next.rdata = s_reg.port_sel;
			`LGST_OFS_CCMODE: s_next.rdata = s_reg.cc_mode;
			`LGST_OFS_LVL_LO: s_next.rdata = {loc_in[2:0], 1'b0, lvl};
			`LGST_OFS_LVL_HI: s_next.rdata = {6'h00, pin9_in, loc_in[3]};
			default: s_next.rdata = 8'h00;
		endcase
		// Link pins
		for (int i = 0; i < 4; i++) begin
			c = link_code(s_reg.std_cfg, i);
			s_next.gpio_oe_n[i] = !(c == `LGST_CODE_FWD || c == `LGST_CODE_LOW ||
				c == `LGST_CODE_HIGH);
			if (c == `LGST_CODE_FWD) begin
				if (fwd_strobe) s_next.gpio_o[i] = fwd_gpio[i];
			end else begin
				s_next.gpio_o[i] = (c == `LGST_CODE_HIGH);
			end
			c = link_code(s_reg.hs_cfg, i);
			s_next.hs_oe_n[i] = !(hs_ok && (c == `LGST_CODE_FWD ||
				c == `LGST_CODE_LOW || c == `LGST_CODE_HIGH));
			if (c == `LGST_CODE_FWD) begin
				if (fwd_strobe && carried[i]) s_next.hs_o[i] = fwd_hs_gpio[i];
			end else begin
				s_next.hs_o[i] = (c == `LGST_CODE_HIGH);
			end
			// Local pins 5..8: registers only, audio loses the pin
			c = (i < 2) ? s_reg.reg56_cfg[i*4 +: 4] : s_reg.reg78_cfg[(i-2)*4 +: 4];
			s_next.loc_oe_n[i] = !(c == `LGST_CODE_LOW || c == `LGST_CODE_HIGH);
			s_next.loc_o[i] = (c == `LGST_CODE_HIGH);
			s_next.aud[i] = is_local(c) ? 1'b0 : aud_pin_in[i];
		end
		c = s_reg.pin9_cfg[3:0];
		s_next.pin9_oe_n = !(c == `LGST_CODE_LOW || c == `LGST_CODE_HIGH);
		s_next.pin9_o = (c == `LGST_CODE_HIGH);
		// Back channel bit clock divider
		fast_bc = s_reg.bc_ctl[`LGST_BIT_FASTBC];
		if (fast_bc) begin
			div_last = `LGST_DIV_FAST;
		end else if (s_reg.bc_ctl[`LGST_BIT_DIVSEL]) begin
			div_last = `LGST_DIV_MID;
		end else begin
			div_last = `LGST_DIV_SLOW;
		end
		s_next.bc_bit = 1'b0;
		if (osc_tick) begin
			if (s_reg.div_cnt >= div_last) begin
				s_next.div_cnt = 2'h0;
				s_next.bc_bit = 1'b1;
			end else begin
				s_next.div_cnt = s_reg.div_cnt + 2'h1;
			end
		end
		// High-speed sampling, limited per frame
		s_next.hs_valid = 1'b0;
		if (bc_frame_start) s_next.smp_cnt = 4'h0;
		if (s_reg.bc_bit && hs_ok && !bc_frame_start && s_reg.smp_cnt < smp_lim) begin
			s_next.smp_cnt = s_reg.smp_cnt + 4'h1;
			s_next.hs_valid = 1'b1;
			for (int i = 0; i < 4; i++) begin
				if (carried[i] && link_code(s_reg.hs_cfg, i) == `LGST_CODE_IN)
					s_next.hs_data[i] = hs_gpio_in[i];
			end
		end
		// Standard inputs sent once per frame
		if (bc_frame_start) begin
			for (int i = 0; i < 4; i++) begin
				s_next.bc_gpio[i] = (link_code(s_reg.std_cfg, i) == `LGST_CODE_IN) &&
					gpio_in[i];
			end
		end
		// Forward SPI regeneration
		if (spi_fwd) begin
			if (fwd_strobe) begin
				s_next.sck_prev = fwd_spi_clk;
				s_next.sck_o = s_reg.sck_prev;
				s_next.ss_n_o = fwd_spi_ss_n;
				if (!s_reg.sck_o && !s_reg.sck_prev) s_next.mosi_o = fwd_spi_mosi;
			end
		end else begin
			s_next.sck_prev = 1'b0;
			s_next.sck_o = 1'b0;
			s_next.ss_n_o = 1'b1;
		end
		// Reverse SPI capture, one sample per frame
		rev_edge = spi_rev && rev_spi_clk && !s_reg.rsck_prev && !rev_spi_ss_n;
		s_next.rsck_prev = rev_spi_clk;
		s_next.spi_valid = 1'b0;
		if (bc_frame_start) begin
			s_next.spi_valid = s_reg.rpend && spi_rev;
			s_next.spi_mosi = s_reg.rmosi;
			s_next.spi_ss_n = spi_rev ? rev_spi_ss_n : 1'b1;
			s_next.rpend = 1'b0;
		end
		if (rev_edge && (!s_reg.rpend || bc_frame_start)) begin
			s_next.rpend = 1'b1;
			s_next.rmosi = rev_spi_mosi;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg <= '0;
			s_reg.std_cfg <= {3{`LGST_RST_CFG}};
			s_reg.hs_cfg <= {3{`LGST_RST_CFG}};
			s_reg.port_sel <= `LGST_RST_PSEL;
			s_reg.gpio_oe_n <= 4'hF;
			s_reg.hs_oe_n <= 4'hF;
			s_reg.loc_oe_n <= 4'hF;
			s_reg.pin9_oe_n <= 1'b1;
			s_reg.ss_n_o <= 1'b1;
			s_reg.spi_ss_n <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata = s_reg.rdata;
	assign bc_bit_strobe = s_reg.bc_bit;
	assign bc_gpio = s_reg.bc_gpio;
	assign bc_hs_valid = s_reg.hs_valid;
	assign bc_hs_data = s_reg.hs_data;
	assign bc_spi_valid = s_reg.spi_valid;
	assign bc_spi_mosi = s_reg.spi_mosi;
	assign bc_spi_ss_n = s_reg.spi_ss_n;
	assign gpio_out = s_reg.gpio_o;
	assign gpio_oe_n = s_reg.gpio_oe_n;
	assign hs_gpio_out = s_reg.hs_o;
	assign hs_gpio_oe_n = s_reg.hs_oe_n;
	assign loc_out = s_reg.loc_o;
	assign loc_oe_n = s_reg.loc_oe_n;
	assign pin9_out = s_reg.pin9_o;
	assign pin9_oe_n = s_reg.pin9_oe_n;
	assign aud_data = s_reg.aud;
	assign tunnel_spi_clock = s_reg.sck_o;
	assign spi_mosi = s_reg.mosi_o;
	assign spi_ss_n = s_reg.ss_n_o;

endmodule

// File: testbench/lgst_gpio_sva.sv
module lgst_gpio_sva (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic pin9_in,
	input wire logic [3:0] loc_in,
	input wire logic two_lane,
	input wire logic fwd_strobe,
	input wire logic bc_frame_start,
	input wire logic bc_bit_strobe,
	input wire logic bc_hs_valid,
	input wire logic bc_spi_valid,
	input wire logic [3:0] hs_gpio_oe_n,
	input wire logic [3:0] loc_oe_n,
	input wire logic [3:0] aud_data,
	input wire logic tunnel_spi_clock,
	input wire logic spi_mosi,
	input wire logic spi_ss_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_level_high_read: assert property (reg_addr == 8'h6F |=>
		reg_rdata == {6'h00, $past(pin9_in), $past(loc_in[3])}) else $error("level read wrong");
	chk_mosi_hold: assert property (tunnel_spi_clock |-> $stable(spi_mosi))
		else $error("mosi moved while clock high");
	chk_clock_on_strobe: assert property ($rose(tunnel_spi_clock) |-> $past(fwd_strobe))
		else $error("spi clock rose without frame");
	chk_hs_after_bit: assert property (bc_hs_valid |-> $past(bc_bit_strobe))
		else $error("sample without bit strobe");
	chk_spi_per_frame: assert property (bc_spi_valid |-> $past(bc_frame_start))
		else $error("spi sample outside frame start");
	chk_hs_lane_off: assert property (!two_lane && $past(!two_lane) |->
		hs_gpio_oe_n == 4'hF) else $error("fast pins driven on one lane");
	chk_spi_lane_off: assert property (!two_lane && $past(!two_lane) |->
		!tunnel_spi_clock && spi_ss_n) else $error("spi active on one lane");
	chk_audio_gate: assert property (((~loc_oe_n) & $past(~loc_oe_n) & aud_data) == 4'h0)
		else $error("audio passed on output pin");
endmodule
bind lgst_gpio_tunnel lgst_gpio_sva u_sva (.*);

// File: testbench/lgst_ser_model.sv
module lgst_ser_model (
	input wire logic clk,
	input wire logic spi_on,
	input wire logic [7:0] rnd,
	output logic fwd_strobe,
	output logic [3:0] fwd_gpio,
	output logic [3:0] fwd_hs_gpio,
	output logic fwd_spi_clk,
	output logic fwd_spi_mosi,
	output logic fwd_spi_ss_n,
	output logic osc_tick,
	output logic bc_frame_start
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt = 8'h00;
	initial {fwd_strobe, fwd_gpio, fwd_hs_gpio, fwd_spi_clk, fwd_spi_mosi} = 11'h000;
	initial {fwd_spi_ss_n, osc_tick, bc_frame_start} = 3'h4;
	// Pixel strobe every 4 cycles, tick every 2, frame every 64
	always @(negedge clk) begin
		cnt <= cnt + 8'h01;
		osc_tick <= cnt[0];
		bc_frame_start <= cnt[5:0] == 6'h3F;
		fwd_strobe <= cnt[1:0] == 2'h3;
		if (cnt[1:0] == 2'h3) begin
			{fwd_hs_gpio, fwd_gpio} <= rnd;
			fwd_spi_ss_n <= !spi_on;
			// Slow master clock, data moves only while low
			fwd_spi_clk <= spi_on && cnt[4];
			if (!cnt[4]) begin
				fwd_spi_mosi <= rnd[0];
			end
		end
	end
endmodule

// File: testbench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, two_lane = 1'h1, strap_mode_select = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rnd = 8'h00;
	logic [3:0] gpio_in = 4'h0, hs_gpio_in = 4'h0, loc_in = 4'h0, aud_pin_in = 4'h0;
	logic pin9_in = 1'h0, rev_spi_clk = 1'h0, rev_spi_mosi = 1'h0, rev_spi_ss_n = 1'h1;
	logic spi_on = 1'h0, frz = 1'h0, mosi_v;
	logic fwd_strobe, fwd_spi_clk, fwd_spi_mosi, fwd_spi_ss_n, osc_tick, bc_frame_start;
	logic [3:0] fwd_gpio, fwd_hs_gpio, bc_gpio, bc_hs_data, gpio_out, gpio_oe_n;
	logic [3:0] hs_gpio_out, hs_gpio_oe_n, loc_out, loc_oe_n, aud_data, hold_v;
	logic bc_bit_strobe, bc_hs_valid, bc_spi_valid, bc_spi_mosi, bc_spi_ss_n;
	logic pin9_out, pin9_oe_n, tunnel_spi_clock, spi_mosi, spi_ss_n;
	logic [31:0] seed = 32'hC250;
	logic [7:0] rate_v[3] = '{8'h00, 8'h40, 8'h10};
	logic [7:0] hs_m[5] = '{8'h00, 8'h03, 8'h02, 8'h01, 8'h04};
	int rate_d[3] = '{4, 2, 1};
	int hs_e[5] = '{1, 6, 10, 15, 1};
	int num_errors = 0, total_checks = 0, n;
	lgst_gpio_tunnel dut (.*);
	lgst_ser_model ser (.*);
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	initial begin
		forever #2 clk = ~clk;
	end
	always @(negedge clk) begin
		seed <= xs(seed);
		rnd <= seed[7:0];
		if (!frz) begin
			{gpio_in, hs_gpio_in, loc_in, aud_pin_in, pin9_in} <= seed[28:12];
		end
	end
	task automatic chk(input logic [7:0] s, e, input string nm);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic near(input int c, e, input string nm);
		chk({7'h00, c >= e - 1 && c <= e + 1}, 8'h01, nm);
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clk);
		reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, e, input string nm);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		chk(reg_rdata, e, nm);
	endtask
	task automatic count(input int c, input logic hs);
		n = 0;
		repeat (c) begin
			@(negedge clk);
			n += hs ? bc_hs_valid : bc_bit_strobe;
		end
	endtask
	task automatic wait_clk(input logic v);
		n = 0;
		while (tunnel_spi_clock !== v && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (n == 100) begin
			num_errors++;
			end_sim();
		end
	endtask
	task automatic tend(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk);
		arst_n = 1'h1;
		rd(8'h34, 8'h01, "port_sel");
		rd(8'h50, 8'h00, "unmapped");
		for (int i = 0; i < 8; i++) begin
			wr(8'h43, 8'(i));
			rd(8'h43, 8'(i), "mode");
		end
		wr(8'h43, 8'h00);
		tend("registers");
		wr(8'h1D, 8'h05);
		repeat (12) @(negedge clk);
		chk({gpio_out[0], gpio_oe_n[0]}, {fwd_gpio[0], 1'h0}, "fwd pin");
		wr(8'h1E, 8'h33);
		frz = 1'h1;
		wr(8'h20, 8'h91);
		wr(8'h21, 8'h30);
		wr(8'h1A, 8'h09);
		repeat (140) @(negedge clk);
		chk(bc_gpio, {1'h0, gpio_in[2:1], 1'h0}, "bc pins");
		chk({pin9_oe_n, pin9_out, loc_oe_n, loc_out[1:0]}, 8'h72, "local pins");
		chk(aud_data, {1'h0, aud_pin_in[2], 2'h0}, "audio");
		rd(8'h6E, {loc_in[2:0], 1'h0, gpio_in}, "level low");
		rd(8'h6F, {6'h00, pin9_in, loc_in[3]}, "level high");
		frz = 1'h0;
		tend("pins");
		foreach (rate_v[i]) begin
			wr(8'h23, rate_v[i]);
			count(160, 1'h0);
			near(n, 80 / rate_d[i], "rate");
		end
		tend("rate");
		wr(8'h34, 8'h02);
		wr(8'h1E, 8'h99);
		repeat (2) @(negedge clk);
		chk({hs_gpio_out[2:1], hs_gpio_oe_n}, 8'h39, "two lane");
		two_lane = 1'h0;
		repeat (3) @(negedge clk);
		chk(hs_gpio_oe_n, 8'h0F, "one lane");
		two_lane = 1'h1;
		wr(8'h1E, 8'h03);
		wr(8'h1D, 8'h03);
		rd(8'h1D, 8'h03, "fast cfg");
		wr(8'h34, 8'h01);
		rd(8'h1D, 8'h05, "std cfg");
		for (int i = 0; i < 5; i++) begin
			wr(8'h43, hs_m[i]);
			count(64, 1'h1);
			hold_v = bc_hs_data;
			count(128, 1'h1);
			near(n, 2 * hs_e[i], "samples");
			if (hs_m[i] == 8'h01) chk(bc_hs_data[3:1], hold_v[3:1], "held pins");
		end
		tend("fast pins");
		wr(8'h43, 8'h06);
		spi_on = 1'h1;
		repeat (400) @(negedge clk);
		chk(spi_ss_n, 8'h00, "spi select");
		wait_clk(1'h0);
		wait_clk(1'h1);
		chk({tunnel_spi_clock, spi_mosi}, {1'h1, fwd_spi_mosi}, "spi rise");
		mosi_v = spi_mosi;
		repeat (13) @(negedge clk);
		chk({tunnel_spi_clock, spi_mosi}, {1'h1, mosi_v}, "spi hold");
		spi_on = 1'h0;
		wr(8'h43, 8'h07);
		rev_spi_ss_n = 1'h0;
		rev_spi_mosi = 1'h1;
		@(negedge clk);
		rev_spi_clk = 1'h1;
		n = 0;
		while (bc_spi_valid !== 1'h1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (n == 200) begin
			num_errors++;
			end_sim();
		end
		chk({bc_spi_valid, bc_spi_mosi, bc_spi_ss_n}, 8'h06, "reverse spi");
		rev_spi_clk = 1'h0;
		rev_spi_ss_n = 1'h1;
		repeat (70) @(negedge clk);
		tend("spi");
		end_sim();
	end
endmodule
